// ==== common/slc_pkg.sv ====
// Constants for the strap latch and serial configuration block
package slc_pkg;
	localparam int CLK_MHZ = 50;
	localparam int STRAP_WIN_US = 2000;
	localparam int STRAP_WIN_CYC = STRAP_WIN_US * CLK_MHZ;
	localparam int FREQ_STEP_US = 20;
	localparam int FREQ_STEP_CYC = FREQ_STEP_US * CLK_MHZ;
	localparam int NUM_DUAL = 5;
	localparam int NUM_CFG = 8;
	localparam int SER_BYTES = 11;
	localparam int SER_HDR = 3;
	localparam logic [7:0] SER_ADDR = 8'hD2;
	localparam logic [7:0] CFG0_RST = 8'h04;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [7:0] CFGX_RST = 8'h00;
	// Byte 0 fields
	localparam int B0_SPREAD_LO = 0;
	localparam int B0_SPREAD_HI = 1;
	localparam int B0_SEL3 = 1;
	localparam int B0_SEL4 = 2;
	localparam int B0_SW_SEL = 3;
	localparam int B0_SEL0 = 4;
	localparam int B0_SEL1 = 5;
	localparam int B0_SEL2 = 6;
	// Dual pin indices
	localparam int PIN_FS0 = 0;
	localparam int PIN_FS1 = 1;
	localparam int PIN_FS2 = 2;
	localparam int PIN_FS3 = 3;
	localparam int PIN_MODE = 4;
	// Bus map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CFG_LO = 4'h8;
	localparam logic [3:0] REG_CFG_HI = 4'hC;
	localparam int CTRL_TRISTATE = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {ST_WAIT_SUPPLY, ST_SAMPLE, ST_LATCHED, ST_RUN} slc_strap_e;
endpackage

// ==== logic/slc_top.sv ====
// Strap latch, serial configuration receiver and register slave
`timescale 1ns/1ps
module slc_top #(
	parameter int STRAP_CYC = slc_pkg::STRAP_WIN_CYC,
	parameter int STEP_CYC = slc_pkg::FREQ_STEP_CYC
) (
	// Clock and power-on reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Supply detector and internal clock sources
	input wire logic supply_ok,
	input wire logic [4:0] clk_src,
	// Dual-purpose pins
	input wire logic [4:0] dual_pin_i,
	output logic [4:0] dual_pin_o,
	output logic [4:0] dual_pin_oe,
	// Serial port
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin_i,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe,
	// Clock synthesis controls
	output logic [4:0] freq_sel,
	output logic spread_cpu,
	output logic spread_pci,
	output logic pin2_mode
);
	localparam int TW = $clog2(STRAP_CYC + 1);
	localparam int SW = $clog2(STEP_CYC + 1);

	// Synchronisers: stage one is read only by stage two
	logic sup_s1_ff, sup_s2_ff;
	logic [4:0] pin_s1_ff, pin_s2_ff;
	logic scl_s1_ff, scl_s2_ff, scl_d_ff;
	logic sda_s1_ff, sda_s2_ff, sda_d_ff;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sup_s1_ff <= 1'b0;
			sup_s2_ff <= 1'b0;
			pin_s1_ff <= 5'h00;
			pin_s2_ff <= 5'h00;
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			sup_s1_ff <= supply_ok;
			sup_s2_ff <= sup_s1_ff;
			pin_s1_ff <= dual_pin_i;
			pin_s2_ff <= pin_s1_ff;
			scl_s1_ff <= serial_clock_pin;
			scl_s2_ff <= scl_s1_ff;
			scl_d_ff <= scl_s2_ff;
			sda_s1_ff <= serial_data_pin_i;
			sda_s2_ff <= sda_s1_ff;
			sda_d_ff <= sda_s2_ff;
		end
	end

	// Strap sequencing
	slc_pkg::slc_strap_e st_ff, nxt_st;
	logic [TW-1:0] tmr_ff;
	logic [4:0] strap_ff;
	wire tmr_done = (tmr_ff == TW'(STRAP_CYC - 1));
	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff)
			slc_pkg::ST_WAIT_SUPPLY: if (sup_s2_ff) nxt_st = slc_pkg::ST_SAMPLE;
			slc_pkg::ST_SAMPLE: if (tmr_done) nxt_st = slc_pkg::ST_LATCHED;
			slc_pkg::ST_LATCHED: nxt_st = slc_pkg::ST_RUN;
			slc_pkg::ST_RUN: nxt_st = slc_pkg::ST_RUN;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= slc_pkg::ST_WAIT_SUPPLY;
			tmr_ff <= '0;
			strap_ff <= 5'h00;
		end
		else
		begin
			st_ff <= nxt_st;
			if (st_ff == slc_pkg::ST_SAMPLE)
				tmr_ff <= tmr_ff + TW'(1);
			// Only latch point; reset is power-on only
			if (st_ff == slc_pkg::ST_SAMPLE && tmr_done)
				strap_ff <= pin_s2_ff;
		end
	end
	wire running = (st_ff == slc_pkg::ST_RUN);

	// Serial receiver, write-only toward the registers
	logic [3:0] bit_ff;
	logic [7:0] shf_ff;
	logic [3:0] idx_ff;
	logic act_ff, addr_ok_ff, ack_ff;
	logic [7:0] cfg_ff [slc_pkg::NUM_CFG];
	wire scl_rise = scl_s2_ff & ~scl_d_ff;
	wire scl_fall = ~scl_s2_ff & scl_d_ff;
	wire start_c = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
	wire stop_c = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
	wire bit_in = act_ff & scl_rise & (bit_ff < 4'd8);
	wire byte_end = bit_in & (bit_ff == 4'd7);
	wire [7:0] byte_v = {shf_ff[6:0], sda_s2_ff};
	wire is_addr = (idx_ff == 4'd0);
	wire is_data = (idx_ff >= 4'(slc_pkg::SER_HDR)) && (idx_ff < 4'(slc_pkg::SER_BYTES));
	wire [3:0] cfg_sel = idx_ff - 4'(slc_pkg::SER_HDR);
	wire addr_hit = is_addr & (byte_v == slc_pkg::SER_ADDR);
	wire cfg_we = byte_end & is_data & addr_ok_ff;
	// The shifter has moved on by the ack fall, so the address verdict is taken from its flop
	wire acked = addr_ok_ff;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			act_ff <= 1'b0;
			bit_ff <= 4'h0;
			shf_ff <= 8'h00;
			idx_ff <= 4'h0;
			addr_ok_ff <= 1'b0;
		end
		else if (start_c)
		begin
			act_ff <= 1'b1;
			bit_ff <= 4'h0;
			idx_ff <= 4'h0;
			addr_ok_ff <= 1'b0;
		end
		else if (stop_c)
			act_ff <= 1'b0;
		else if (act_ff && scl_rise)
		begin
			if (bit_ff == 4'd8)
			begin
				// The ninth (acknowledge) clock of every byte only advances the count
				bit_ff <= 4'h0;
				if (idx_ff != 4'hF)
					idx_ff <= idx_ff + 4'h1;
			end
			else
			begin
				bit_ff <= bit_ff + 4'h1;
				shf_ff <= byte_v;
				if (byte_end && is_addr)
					addr_ok_ff <= addr_hit;
			end
		end
	end

	// Acknowledge is the only drive on the data pin; data never goes back
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ack_ff <= 1'b0;
		else if (start_c || stop_c)
			ack_ff <= 1'b0;
		else if (scl_fall)
			ack_ff <= act_ff && bit_ff == 4'd8 && acked && !ack_ff;
	end
	assign serial_data_pin_o = 1'b0;
	assign serial_data_pin_oe = ack_ff;

	// Control bytes
	genvar gi;
	for (gi = 0; gi < slc_pkg::NUM_CFG; gi++)
	begin : g_cfg
		localparam logic [7:0] RV = (gi == 0) ? slc_pkg::CFG0_RST :
			(gi == 1) ? slc_pkg::CFG1_RST : slc_pkg::CFGX_RST;
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cfg_ff[gi] <= RV;
			else if (cfg_we && cfg_sel == 4'(gi))
				cfg_ff[gi] <= byte_v;
		end
	end

	// Frequency target and gradual step
	wire [7:0] b0 = cfg_ff[0];
	wire [4:0] hw_sel = {1'b0, strap_ff[slc_pkg::PIN_FS3:slc_pkg::PIN_FS0]};
	wire [4:0] sw_sel = {b0[slc_pkg::B0_SEL4], b0[slc_pkg::B0_SEL3], b0[slc_pkg::B0_SEL2],
		b0[slc_pkg::B0_SEL1], b0[slc_pkg::B0_SEL0]};
	wire [4:0] tgt_sel = b0[slc_pkg::B0_SW_SEL] ? sw_sel : hw_sel;
	wire spread_on = b0[slc_pkg::B0_SPREAD_HI] | b0[slc_pkg::B0_SPREAD_LO];
	logic [SW-1:0] stp_ff;
	wire stp_tick = (stp_ff == SW'(STEP_CYC - 1));
	logic [4:0] nxt_freq;
	always_comb
	begin
		nxt_freq = freq_sel;
		if (st_ff == slc_pkg::ST_LATCHED)
			nxt_freq = hw_sel;
		else if (running && stp_tick && freq_sel < tgt_sel)
			nxt_freq = freq_sel + 5'h01;
		else if (running && stp_tick && freq_sel > tgt_sel)
			nxt_freq = freq_sel - 5'h01;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stp_ff <= '0;
			freq_sel <= 5'h00;
			spread_cpu <= 1'b0;
			spread_pci <= 1'b0;
			pin2_mode <= 1'b0;
		end
		else
		begin
			stp_ff <= stp_tick ? '0 : stp_ff + SW'(1);
			freq_sel <= nxt_freq;
			spread_cpu <= running & spread_on;
			spread_pci <= running & spread_on;
			pin2_mode <= strap_ff[slc_pkg::PIN_MODE];
		end
	end

	// Bus control register
	logic [31:0] ctrl_ff;
	wire tri_on = ctrl_ff[slc_pkg::CTRL_TRISTATE];
	wire [4:0] out_en = ~cfg_ff[1][4:0];

	// Dual pin drivers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dual_pin_oe <= 5'h00;
			dual_pin_o <= 5'h00;
		end
		else
		begin
			// Buffers open two cycles after the latch; a runt edge is tolerated
			dual_pin_oe <= {5{running & ~tri_on}};
			dual_pin_o <= clk_src & out_en;
		end
	end

	// AXI4-Lite write side: address and data taken in either order
	logic aw_h_ff, w_h_ff;
	logic [3:0] awa_ff;
	logic [31:0] wd_ff;
	logic [3:0] ws_ff;
	wire wr_go = aw_h_ff & w_h_ff & ~s_axi_bvalid;
	wire wr_hit = (awa_ff[3:2] == slc_pkg::REG_CTRL[3:2]) && (awa_ff[1:0] == 2'b00);
	logic [31:0] nxt_ctrl;
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		for (int b = 0; b < 4; b++)
			if (ws_ff[b])
				nxt_ctrl[8*b +: 8] = wd_ff[8*b +: 8];
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_h_ff <= 1'b0;
			w_h_ff <= 1'b0;
			awa_ff <= 4'h0;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= slc_pkg::RESP_OKAY;
			ctrl_ff <= slc_pkg::CTRL_RST;
		end
		else
		begin
			s_axi_awready <= ~aw_h_ff & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_h_ff & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_h_ff <= 1'b1;
				awa_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_h_ff <= 1'b1;
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_h_ff <= 1'b0;
				w_h_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? slc_pkg::RESP_OKAY : slc_pkg::RESP_DECERR;
				if (wr_hit)
					ctrl_ff <= nxt_ctrl & 32'h0000_0001;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read side
	wire [31:0] stat_w = {16'h0000, 3'h0, freq_sel, 1'b0, strap_ff, st_ff};
	wire [31:0] cfg_lo = {cfg_ff[3], cfg_ff[2], cfg_ff[1], cfg_ff[0]};
	wire [31:0] cfg_hi = {cfg_ff[7], cfg_ff[6], cfg_ff[5], cfg_ff[4]};
	wire [31:0] rd_mux = (s_axi_araddr == slc_pkg::REG_CTRL) ? ctrl_ff :
		(s_axi_araddr == slc_pkg::REG_STAT) ? stat_w :
		(s_axi_araddr == slc_pkg::REG_CFG_LO) ? cfg_lo :
		(s_axi_araddr == slc_pkg::REG_CFG_HI) ? cfg_hi : 32'h0000_0000;
	wire rd_ok = (s_axi_araddr[1:0] == 2'b00);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= slc_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? slc_pkg::RESP_OKAY : slc_pkg::RESP_DECERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	property p_hold_tristate;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff != slc_pkg::ST_RUN) |=> (dual_pin_oe == 5'h00);
	endproperty
	a_hold_tristate: assert property (p_hold_tristate) else $error("pins driven early");
	property p_latch_then_enable;
		@(posedge aclk) disable iff (!aresetn)
		$rose(dual_pin_oe[0])
			|-> ($past(st_ff) == slc_pkg::ST_RUN) && ($past(st_ff, 2) != slc_pkg::ST_SAMPLE);
	endproperty
	a_latch_then_enable: assert property (p_latch_then_enable) else $error("enable before latch");
	property p_timer_start;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == slc_pkg::ST_WAIT_SUPPLY && sup_s2_ff) |=> (st_ff == slc_pkg::ST_SAMPLE && tmr_ff == '0);
	endproperty
	a_timer_start: assert property (p_timer_start) else $error("timer did not start");
	property p_straps_stable;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == slc_pkg::ST_RUN) |=> $stable(strap_ff);
	endproperty
	a_straps_stable: assert property (p_straps_stable) else $error("strap changed");
	property p_latch_level;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == slc_pkg::ST_SAMPLE && tmr_done) |=> (strap_ff == $past(pin_s2_ff));
	endproperty
	a_latch_level: assert property (p_latch_level) else $error("strap level wrong");
	property p_spread_gate;
		@(posedge aclk) disable iff (!aresetn)
		spread_cpu |-> ($past(running) && spread_pci);
	endproperty
	a_spread_gate: assert property (p_spread_gate) else $error("spread outside run");
	property p_bad_addr;
		@(posedge aclk) disable iff (!aresetn)
		(act_ff && !is_addr && !addr_ok_ff) |=> $stable(cfg_lo) && $stable(cfg_hi);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("foreign write landed");
	property p_disable_low;
		@(posedge aclk) disable iff (!aresetn)
		!out_en[0] |=> !dual_pin_o[0];
	endproperty
	a_disable_low: assert property (p_disable_low) else $error("disabled pin toggles");
	property p_step;
		@(posedge aclk) disable iff (!aresetn)
		running && $past(running) && freq_sel != $past(freq_sel)
			|-> (freq_sel - $past(freq_sel) == 5'h01) || ($past(freq_sel) - freq_sel == 5'h01);
	endproperty
	a_step: assert property (p_step) else $error("frequency jumped");
	property p_tristate;
		@(posedge aclk) disable iff (!aresetn)
		tri_on |=> (dual_pin_oe == 5'h00);
	endproperty
	a_tristate: assert property (p_tristate) else $error("three-state ignored");
endmodule // slc_top

// ==== verification/slc_ser_master.sv ====
// Chipset-side model that writes configuration frames over the two-wire port
`timescale 1ns/1ps
module slc_ser_master (
	// Two-wire link, data is open-drain with a pull-up
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	// Clock rests high and data is released between frames
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Data only moves while the clock is low
	task automatic put(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b0;
		for (int i = 7; i > 7 - n; i--)
		begin
			sda_drv = b[i];
			#40 scl = 1'b1;
			#80 scl = 1'b0;
			#40;
		end
		if (n == 8)
		begin
			sda_drv = 1'b1;
			#40 scl = 1'b1;
			// Late sample leaves room for the receiver's synchronisers
			#80 ack = !sda;
			scl = 1'b0;
			#40;
		end
	endtask
	// Address, command, count, then whole data bytes and an optional cut byte
	task automatic frame(input logic [7:0] adr, input logic [7:0] d [8], input int full,
		input int part, output logic ack0);
		logic a;
		sda_drv = 1'b1;
		#40 sda_drv = 1'b0;
		#40 scl = 1'b0;
		#40;
		put(adr, 8, ack0);
		put(8'h00, 8, a);
		put(8'h08, 8, a);
		for (int k = 0; k < full; k++)
			put(d[k], 8, a);
		if (part > 0)
			put(d[full], part, a);
		sda_drv = 1'b0;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b1;
		#40;
	endtask
endmodule // slc_ser_master

// ==== verification/strap_latch_serial_config_tb_top.sv ====
// Self-checking bench for the strap latch and serial configuration block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module strap_latch_serial_config_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_ok = 1'b0, watch_fs = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ack;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [4:0] clk_src = 5'h1F, dual_pin_i = 5'h16, dual_pin_o, dual_pin_oe, freq_sel;
	logic [4:0] fs_prev = 5'h00;
	logic serial_clock_pin, serial_data_pin_o, serial_data_pin_oe, sda_drv;
	logic spread_cpu, spread_pci, pin2_mode;
	logic [7:0] cfg [8];
	wire serial_data_pin_i = sda_drv & ~serial_data_pin_oe;
	int bad_count = 0, checked = 0, n;

	slc_top #(.STRAP_CYC(50), .STEP_CYC(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_ok, .clk_src, .dual_pin_i, .dual_pin_o,
		.dual_pin_oe, .serial_clock_pin, .serial_data_pin_i, .serial_data_pin_o,
		.serial_data_pin_oe, .freq_sel, .spread_cpu, .spread_pci, .pin2_mode);
	slc_ser_master i_ser (.scl(serial_clock_pin), .sda_drv, .sda(serial_data_pin_i));

	initial
	begin
		forever #10 aclk = ~aclk;
	end
	// Any change of the frequency select must be a single step
	always @(posedge aclk)
	begin
		if (watch_fs && freq_sel !== fs_prev)
			`CHK((freq_sel - fs_prev == 5'h01) || (fs_prev - freq_sel == 5'h01), 1'b1)
		fs_prev <= freq_sel;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 200)
		begin
			bad_count++;
			$display("Error at %0t: wait ran out, got %0h expected %0h", $time, k, 0);
			stop_test();
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && k < 200);
		tmo(k);
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && k < 200);
		tmo(k);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a, rd, rr);
		`CHK(rd & m, e)
		`CHK(rr, slc_pkg::RESP_OKAY)
	endtask
	task automatic ser(input logic [7:0] adr, input int full, input int part);
		// Link edges kept off the sampling edge of aclk
		#5;
		i_ser.frame(adr, cfg, full, part, ack);
		repeat (10) @(posedge aclk);
	endtask
	// Counts cycles from now until the dual pins start driving
	task automatic wait_oe();
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (dual_pin_oe === 5'h00 && n < 200);
		tmo(n);
	endtask

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		`CHK(dual_pin_oe, 5'h00)
		supply_ok <= 1'b1;
		wait_oe();
		// Two sync stages, the window, then latch before enable
		`CHK(n >= 50 && n <= 60, 1'b1)
		`CHK(dual_pin_oe, 5'h1F)
		`CHK(freq_sel, 5'h06)
		`CHK(pin2_mode, 1'b1)
		watch_fs <= 1'b1;
		rd_chk(slc_pkg::REG_STAT, 32'h0000_007C, 32'h0000_0058);
		dual_pin_i <= 5'h09;
		$display("Test strap latch done");
		cfg = '{default: 8'hFF};
		ser(8'hD3, 8, 0);
		`CHK(ack, 1'b0)
		rd_chk(slc_pkg::REG_CFG_LO, 32'hFFFF_FFFF, 32'h0000_0004);
		rd_chk(slc_pkg::REG_CFG_HI, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK(spread_cpu, 1'b0)
		`CHK(serial_data_pin_o, 1'b0)
		$display("Test foreign address done");
		cfg = '{8'h0B, 8'h01, 8'h5A, 8'h3C, 8'hA5, 8'h96, 8'h11, 8'h00};
		ser(8'hD2, 8, 0);
		`CHK(ack, 1'b1)
		rd_chk(slc_pkg::REG_CFG_LO, 32'hFFFF_FFFF, 32'h3C5A_010B);
		rd_chk(slc_pkg::REG_CFG_HI, 32'hFFFF_FFFF, 32'h0011_96A5);
		`CHK({spread_cpu, spread_pci}, 2'h3)
		`CHK(dual_pin_o, 5'h1E)
		`CHK(dual_pin_oe, 5'h1F)
		clk_src <= 5'h0B;
		repeat (2) @(posedge aclk);
		`CHK(dual_pin_o, 5'h0A)
		n = 0;
		while (freq_sel !== 5'h08 && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
		rd_chk(slc_pkg::REG_STAT, 32'h0000_1F7C, 32'h0000_0858);
		$display("Test full frame done");
		cfg[0] = 8'h00;
		cfg[1] = 8'hFF;
		ser(8'hD2, 1, 4);
		rd_chk(slc_pkg::REG_CFG_LO, 32'h0000_FFFF, 32'h0000_0100);
		`CHK(spread_cpu, 1'b0)
		$display("Test cut frame done");
		axi_wr(slc_pkg::REG_CTRL, 32'h0000_0001, slc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(dual_pin_oe, 5'h00)
		rd_chk(slc_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
		axi_wr(slc_pkg::REG_CTRL, 32'h0000_0000, slc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(dual_pin_oe, 5'h1F)
		axi_wr(slc_pkg::REG_CFG_LO, 32'h0000_0000, slc_pkg::RESP_DECERR);
		$display("Test register bus done");
		// Reset stands in for a supply cycle, so straps resample
		watch_fs <= 1'b0;
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wait_oe();
		rd_chk(slc_pkg::REG_STAT, 32'h0000_007C, 32'h0000_0024);
		rd_chk(slc_pkg::REG_CFG_LO, 32'hFFFF_FFFF, 32'h0000_0004);
		$display("Test power cycle done");
		stop_test();
	end
endmodule // strap_latch_serial_config_tb_top
